// ---- inc/ulms_pkg.sv ----
// types shared by the line/modem status block and its pin synchroniser
// assumes nothing beyond a systemverilog compiler
package ulms_pkg;

    typedef struct packed {
        logic       brk;
        logic       frame_err;
        logic       parity_err;
        logic [7:0] data;
    } ulms_rx_char_t;

    // order matches modem status bits 7..4
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } ulms_modem_t;

    typedef struct packed {
        ulms_modem_t s1;
        ulms_modem_t s2;
    } ulms_sync_t;

    typedef struct packed {
        ulms_rx_char_t [15:0] mem;
        logic [3:0]           wr_ptr;
        logic [3:0]           rd_ptr;
        logic [4:0]           count;
        logic                 overrun;
        logic [4:0]           mctl;
        logic                 fifo_en;
        logic [3:0]           delta;
        ulms_modem_t          prev;
        logic [1:0]           settle;
        logic [3:0]           irq_st;
        logic [3:0]           irq_mask;
        logic                 aw_got;
        logic                 w_got;
        logic [7:0]           waddr;
        logic [7:0]           wdata;
        logic                 wbyte;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } ulms_state_t;

endpackage

// ---- inc/ulms_regs.svh ----
// register offsets, field positions, reset values and counts of the line/modem status block
// assumes a 32-bit axi4-lite slave decoding byte address bits [7:0]
`ifndef ULMS_REGS_SVH
`define ULMS_REGS_SVH

`define ULMS_OFF_RX_HOLD      8'h00
`define ULMS_OFF_LINE_STATUS  8'h04
`define ULMS_OFF_MODEM_STATUS 8'h08
`define ULMS_OFF_MODEM_CTRL   8'h0C
`define ULMS_OFF_FIFO_CTRL    8'h10
`define ULMS_OFF_IRQ_STATUS   8'h14
`define ULMS_OFF_IRQ_MASK     8'h18

`define ULMS_LS_READY    0
`define ULMS_LS_OVERRUN  1
`define ULMS_LS_PARITY   2
`define ULMS_LS_FRAMING  3
`define ULMS_LS_BREAK    4
`define ULMS_LS_FIFO_ERR 7

`define ULMS_MS_DCTS 0
`define ULMS_MS_DDSR 1
`define ULMS_MS_TERI 2
`define ULMS_MS_DCD  3

`define ULMS_MC_DTR  0
`define ULMS_MC_RTS  1
`define ULMS_MC_OUT1 2
`define ULMS_MC_OUT2 3
`define ULMS_MC_LOOP 4

`define ULMS_IRQ_MODEM   0
`define ULMS_IRQ_OVERRUN 1
`define ULMS_IRQ_RXCHAR  2
`define ULMS_IRQ_RXERR   3

`define ULMS_RST_MODEM_CTRL 5'h00
`define ULMS_RST_FIFO_EN    1'h0
`define ULMS_RST_IRQ_MASK   4'h0
`define ULMS_RST_PIN_SYNC   4'hF

`define ULMS_FIFO_DEPTH  5'h10
`define ULMS_SYNC_SETTLE 2'h3

`define ULMS_RESP_OKAY   2'h0
`define ULMS_RESP_SLVERR 2'h2

`endif

// ---- logic/ulms_sync.sv ----
// two-flop synchroniser for the four active-low modem control pins
// assumes the pins are asynchronous and idle high
`include "ulms_regs.svh"

module ulms_sync (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire ulms_pkg::ulms_modem_t pin_n,
    output ulms_pkg::ulms_modem_t      pin_sync_n
);
    ulms_pkg::ulms_sync_t st;
    ulms_pkg::ulms_sync_t next_st;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_bit
            always_comb begin
                next_st.s1[i] = pin_n[i];
                next_st.s2[i] = st.s1[i];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= {`ULMS_RST_PIN_SYNC, `ULMS_RST_PIN_SYNC};
        end else begin
            st <= next_st;
        end
    end

    assign pin_sync_n = st.s2;
endmodule

// ---- logic/ulms_top.sv ----
// line status and modem status of one uart channel, with receive fifo and axi4-lite slave
// assumes the receiver pulses rx_valid once per finished character, synchronous to clk
//
// What this block does
// - parity error flagged for head character
// - overrun set when character meets full fifo
// - overrun drops new byte, fifo untouched
// - data ready while any character waits
// - bit 7: inverted carrier, loopback control bit 3
// - bit 6: inverted ring, loopback control bit 2
// - bit 5: inverted dsr, loopback control bit 0
// - bit 4: inverted cts, loopback control bit 1
// - carrier, dsr, cts deltas on any change
// - ring delta only on rising ring pin
// - modem status read clears all deltas
// - any delta raises modem status interrupt
// - fifo error summary while errored character held
// - reset clears deltas, upper bits live
`include "ulms_regs.svh"

module ulms_top (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [7:0]             awaddr,
    input  wire logic                   wvalid,
    output logic                        wready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    output logic                        bvalid,
    input  wire logic                   bready,
    output logic [1:0]                  bresp,
    input  wire logic                   arvalid,
    output logic                        arready,
    input  wire logic [7:0]             araddr,
    output logic                        rvalid,
    input  wire logic                   rready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    input  wire logic                   rx_valid,
    input  wire ulms_pkg::ulms_rx_char_t rx_char,
    input  wire ulms_pkg::ulms_modem_t   modem_in_n,
    output logic                        dtr_n,
    output logic                        rts_n,
    output logic                        user_output_one_n,
    output logic                        user_output_two_n,
    output logic                        modem_irq,
    output logic                        irq
);
    ulms_pkg::ulms_state_t   st;
    ulms_pkg::ulms_state_t   next_st;
    ulms_pkg::ulms_modem_t   pin_sync_n;
    ulms_pkg::ulms_modem_t   ms_live;
    ulms_pkg::ulms_modem_t   ms_chg;
    ulms_pkg::ulms_rx_char_t head;
    logic [3:0]              delta_set;
    logic [3:0]              irq_set;
    logic [15:0]             occ;
    logic [15:0]             err_at;
    logic [7:0]              line_status;
    logic [7:0]              modem_status;
    logic [4:0]              cap;
    logic                    loopback;
    logic                    settled;
    logic                    ri_rise;
    logic                    empty;
    logic                    full;
    logic                    push;
    logic                    pop;
    logic                    ovr_evt;
    logic                    ar_take;
    logic                    aw_take;
    logic                    w_take;
    logic                    do_wr;
    logic                    rd_ms;
    logic                    rd_ls;
    logic                    rd_rx;

    ulms_sync u_sync (
        .clk        (clk),
        .resetn     (resetn),
        .pin_n      (modem_in_n),
        .pin_sync_n (pin_sync_n)
    );

    assign loopback = st.mctl[`ULMS_MC_LOOP];
    assign settled  = (st.settle == `ULMS_SYNC_SETTLE);

    always_comb begin
        if (loopback) begin
            ms_live.cd  = st.mctl[`ULMS_MC_OUT2];
            ms_live.ri  = st.mctl[`ULMS_MC_OUT1];
            ms_live.dsr = st.mctl[`ULMS_MC_DTR];
            ms_live.cts = st.mctl[`ULMS_MC_RTS];
        end else begin
            ms_live = ~pin_sync_n;
        end
    end

    assign ms_chg  = ms_live ^ st.prev;
    // ring pin rising, so the status bit falling
    assign ri_rise = ~ms_live.ri & st.prev.ri;
    assign delta_set = {ms_chg.cd, ri_rise, ms_chg.dsr, ms_chg.cts} & {4{settled}};

    // upper half live, lower half the deltas latched since the last read
    assign modem_status = {ms_live, st.delta};

    // receive fifo; depth one when the fifo is off, acting as the holding register
    assign cap   = st.fifo_en ? `ULMS_FIFO_DEPTH : 5'h01;
    assign empty = (st.count == 5'h00);
    assign full  = (st.count >= cap);
    assign head  = st.mem[st.rd_ptr];

    // occupied entries with any receive error
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_ent
            assign occ[i]    = ({1'b0, 4'(i) - st.rd_ptr} < st.count);
            assign err_at[i] = occ[i] & (st.mem[i].parity_err | st.mem[i].frame_err
                                         | st.mem[i].brk);
        end
    endgenerate

    // parity, framing and break bits follow the head character
    always_comb begin
        line_status = 8'h00;
        line_status[`ULMS_LS_READY]    = !empty;
        line_status[`ULMS_LS_OVERRUN]  = st.overrun;
        line_status[`ULMS_LS_PARITY]   = !empty & head.parity_err;
        line_status[`ULMS_LS_FRAMING]  = !empty & head.frame_err;
        line_status[`ULMS_LS_BREAK]    = !empty & head.brk;
        line_status[`ULMS_LS_FIFO_ERR] = |err_at;
    end

    // bus handshakes; one write and one read in flight at most
    assign awready = !st.aw_got & !st.bvalid;
    assign wready  = !st.w_got & !st.bvalid;
    assign arready = !st.rvalid;
    assign aw_take = awvalid & awready;
    assign w_take  = wvalid & wready;
    assign ar_take = arvalid & arready;
    assign do_wr   = st.aw_got & st.w_got;
    assign rd_ms   = ar_take & (araddr == `ULMS_OFF_MODEM_STATUS);
    assign rd_ls   = ar_take & (araddr == `ULMS_OFF_LINE_STATUS);
    assign rd_rx   = ar_take & (araddr == `ULMS_OFF_RX_HOLD);

    // arrival while full is an overrun
    assign ovr_evt = rx_valid & full;
    // a byte meeting a full fifo is dropped
    assign push    = rx_valid & !full;
    assign pop     = rd_rx & !empty;

    // modem cause follows any set delta
    assign irq_set[`ULMS_IRQ_MODEM]   = |st.delta;
    assign irq_set[`ULMS_IRQ_OVERRUN] = ovr_evt;
    assign irq_set[`ULMS_IRQ_RXCHAR]  = push;
    assign irq_set[`ULMS_IRQ_RXERR]   = push & (rx_char.parity_err | rx_char.frame_err
                                                | rx_char.brk);

    always_comb begin
        next_st = st;
        next_st.prev = ms_live;
        if (!settled) begin
            next_st.settle = st.settle + 2'h1;
        end
        // a fresh change wins over the clear
        next_st.delta = (st.delta & ~{4{rd_ms}}) | delta_set;

        if (push) begin
            next_st.mem[st.wr_ptr] = rx_char;
            next_st.wr_ptr         = st.wr_ptr + 4'h1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 4'h1;
        end
        case ({push, pop})
            2'b10:   next_st.count = st.count + 5'h01;
            2'b01:   next_st.count = st.count - 5'h01;
            default: next_st.count = st.count;
        endcase
        // sticky until line status is read
        next_st.overrun = (st.overrun & ~rd_ls) | ovr_evt;

        // sticky causes, set on the event
        next_st.irq_st = st.irq_st | irq_set;

        if (aw_take) begin
            next_st.aw_got = 1'b1;
            next_st.waddr  = awaddr;
        end
        if (w_take) begin
            next_st.w_got = 1'b1;
            next_st.wdata = wdata[7:0];
            next_st.wbyte = wstrb[0];
        end
        if (st.bvalid & bready) begin
            next_st.bvalid = 1'b0;
        end
        if (do_wr) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = `ULMS_RESP_OKAY;
            case (st.waddr)
                `ULMS_OFF_MODEM_CTRL: begin
                    if (st.wbyte) begin
                        next_st.mctl = st.wdata[4:0];
                    end
                end
                `ULMS_OFF_FIFO_CTRL: begin
                    // switching mode flushes, since old entries would not fit the new depth
                    if (st.wbyte && (st.wdata[0] != st.fifo_en)) begin
                        next_st.fifo_en = st.wdata[0];
                        next_st.count   = 5'h00;
                        next_st.wr_ptr  = 4'h0;
                        next_st.rd_ptr  = 4'h0;
                    end
                end
                `ULMS_OFF_IRQ_STATUS: begin
                    // set wins over write-one-to-clear
                    if (st.wbyte) begin
                        next_st.irq_st = (st.irq_st & ~st.wdata[3:0]) | irq_set;
                    end
                end
                `ULMS_OFF_IRQ_MASK: begin
                    if (st.wbyte) begin
                        next_st.irq_mask = st.wdata[3:0];
                    end
                end
                `ULMS_OFF_RX_HOLD, `ULMS_OFF_LINE_STATUS, `ULMS_OFF_MODEM_STATUS: begin
                    next_st.bresp = `ULMS_RESP_OKAY;
                end
                default: next_st.bresp = `ULMS_RESP_SLVERR;
            endcase
        end

        if (st.rvalid & rready) begin
            next_st.rvalid = 1'b0;
        end
        if (ar_take) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `ULMS_RESP_OKAY;
            case (araddr)
                `ULMS_OFF_RX_HOLD:      next_st.rdata = {24'h000000, empty ? 8'h00 : head.data};
                `ULMS_OFF_LINE_STATUS:  next_st.rdata = {24'h000000, line_status};
                `ULMS_OFF_MODEM_STATUS: next_st.rdata = {24'h000000, modem_status};
                `ULMS_OFF_MODEM_CTRL:   next_st.rdata = {27'h0000000, st.mctl};
                `ULMS_OFF_FIFO_CTRL:    next_st.rdata = {31'h00000000, st.fifo_en};
                `ULMS_OFF_IRQ_STATUS:   next_st.rdata = {28'h0000000, st.irq_st};
                `ULMS_OFF_IRQ_MASK:     next_st.rdata = {28'h0000000, st.irq_mask};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = `ULMS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st          <= '0;
            st.mctl     <= `ULMS_RST_MODEM_CTRL;
            st.fifo_en  <= `ULMS_RST_FIFO_EN;
            st.irq_mask <= `ULMS_RST_IRQ_MASK;
            st.prev     <= ~`ULMS_RST_PIN_SYNC;
        end else begin
            st <= next_st;
        end
    end

    assign bvalid = st.bvalid;
    assign bresp  = st.bresp;
    assign rvalid = st.rvalid;
    assign rdata  = st.rdata;
    assign rresp  = st.rresp;
    // control pins idle high in loopback, their levels feed the status bits instead
    assign dtr_n             = loopback | ~st.mctl[`ULMS_MC_DTR];
    assign rts_n             = loopback | ~st.mctl[`ULMS_MC_RTS];
    assign user_output_one_n = loopback | ~st.mctl[`ULMS_MC_OUT1];
    assign user_output_two_n = loopback | ~st.mctl[`ULMS_MC_OUT2];
    // condition output while any delta set
    assign modem_irq = |st.delta;
    assign irq       = |(st.irq_st & st.irq_mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_ms_read;
        rd_ms;
    endsequence
    sequence s_no_change;
        delta_set == 4'h0;
    endsequence

    a_ri_rise_only: assert property (
        (!st.delta[2] && !$fell(ms_live.ri)) |=> !st.delta[2])
        else $error("ring delta set without a rising ring input");
    a_ri_rise_sets: assert property (
        (settled && $fell(ms_live.ri)) |=> st.delta[2])
        else $error("rising ring input did not set its delta");
    a_delta_change: assert property (
        (settled && $changed(ms_live.cd)) |=> st.delta[3] && modem_irq)
        else $error("carrier change did not set its delta");
    a_read_clears: assert property (
        (s_ms_read and s_no_change) |=> (st.delta == 4'h0)
            ##1 (st.delta == 4'h0 || |delta_set[3:0] || $past(|delta_set)))
        else $error("modem status read left a delta set");
    a_change_kept: assert property (
        (rd_ms && delta_set[0]) |=> st.delta[0])
        else $error("change during modem status read was lost");
    a_loop_bits: assert property (
        (rd_ms && loopback) |=> st.rvalid
            && st.rdata[7:4] == {$past(st.mctl[3]), $past(st.mctl[2]),
                                 $past(st.mctl[0]), $past(st.mctl[1])})
        else $error("loopback status bits do not follow modem control");
    a_norm_bits: assert property (
        (rd_ms && !loopback) |=> st.rdata[7:4] == ~$past(pin_sync_n))
        else $error("status bits are not the inverted synchronised pins");
    a_overrun_hold: assert property (
        (ovr_evt && !rd_rx) |=> st.overrun && st.count == $past(st.count)
            && st.wr_ptr == $past(st.wr_ptr))
        else $error("overrun changed the fifo contents");
    a_overrun_sets: assert property (
        ovr_evt |=> st.overrun)
        else $error("arrival at a full fifo did not set overrun");
    a_ready_bit: assert property (
        rd_ls |=> st.rdata[0] == ($past(st.count) != 5'h00))
        else $error("data ready bit disagrees with fifo fill");
    a_modem_irq: assert property (
        (|st.delta) |=> st.irq_st[0] ##1 (st.irq_st[0] || $past(do_wr)))
        else $error("set delta did not raise the modem interrupt cause");
    a_write_resp: assert property (
        (st.aw_got && st.w_got) |=> st.bvalid && !st.aw_got && !st.w_got)
        else $error("write was not answered one cycle after both halves");
endmodule

// ---- verif/ulms_modem_model.sv ----
// modem side: drives the four active-low control pins
// assumes the bench sets the wanted levels; pins idle high as if pulled up
module ulms_modem_model (
    input  wire logic                  clk,
    input  wire ulms_pkg::ulms_modem_t want_n,
    output ulms_pkg::ulms_modem_t      pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin_n = 4'hF;
    // pins follow the wanted levels one edge later, like a registered line driver
    always @(posedge clk) begin
        pin_n <= want_n;
    end
endmodule

// ---- verif/ulms_top_tb_top.sv ----
// self-checking bench for the line and modem status block
// assumes a 125 MHz clock and the modem model on the control pins
`include "ulms_regs.svh"

module ulms_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic                    arvalid, arready, rvalid, rready, rx_valid, modem_irq, irq;
    logic                    dtr_n, rts_n, user_output_one_n, user_output_two_n;
    logic [7:0]              awaddr, araddr;
    logic [31:0]             wdata, rdata, v;
    logic [3:0]              wstrb;
    logic [1:0]              bresp, rresp, r;
    ulms_pkg::ulms_rx_char_t rx_char;
    ulms_pkg::ulms_modem_t   want_n, pin_n;
    int                      fail_count, checks_done;

    ulms_top ulms_top_inst (
        .clk(clk), .resetn(resetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .rx_valid(rx_valid),
        .rx_char(rx_char), .modem_in_n(pin_n), .dtr_n(dtr_n), .rts_n(rts_n),
        .user_output_one_n(user_output_one_n), .user_output_two_n(user_output_two_n),
        .modem_irq(modem_irq), .irq(irq)
    );

    ulms_modem_model ulms_modem_model_inst (
        .clk(clk), .want_n(want_n), .pin_n(pin_n)
    );

    always #4 clk = ~clk;

    task automatic stop_test();
        if (fail_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic hang();
        fail_count++;
        $display("ERROR handshake expected answer seen none");
        stop_test();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge clk);
        awvalid <= 1'h1;
        awaddr <= a;
        wvalid <= 1'h1;
        wdata <= d;
        bready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'h0;
                break;
            end
        end
        if (n == 64) hang();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge clk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'h0;
                break;
            end
        end
        if (n == 64) hang();
    endtask

    // back to back characters, one per cycle
    task automatic push(input int cnt, input logic [10:0] c);
        for (int i = 0; i < cnt; i++) begin
            @(posedge clk);
            rx_valid <= 1'h1;
            rx_char <= c + 11'(i);
        end
        @(posedge clk);
        rx_valid <= 1'h0;
    endtask

    task automatic t_reset();
        rd(`ULMS_OFF_MODEM_STATUS, v, r);
        chk("modem_status", 32'h0, v);
        chk("modem_irq", 32'h0, {31'h0, modem_irq});
        chk("control pins", 32'hF, {28'h0, dtr_n, rts_n, user_output_one_n, user_output_two_n});
        rd(`ULMS_OFF_LINE_STATUS, v, r);
        chk("line_status", 32'h0, v);
    endtask

    // each pin falls then rises; ring flags only its rising pin edge
    task automatic t_modem();
        logic [3:0] d;
        for (int b = 0; b < 4; b++) begin
            for (int l = 0; l < 2; l++) begin
                @(posedge clk);
                want_n[b] <= l[0];
                repeat (6) @(posedge clk);
                d = (b == 2 && l == 0) ? 4'h0 : 4'h1 << b;
                chk("modem_irq", {31'h0, d != 4'h0}, {31'h0, modem_irq});
                rd(`ULMS_OFF_MODEM_STATUS, v, r);
                chk("modem_status", {24'h0, ~want_n, d}, v);
                rd(`ULMS_OFF_MODEM_STATUS, v, r);
                chk("modem_status cleared", {24'h0, ~want_n, 4'h0}, v);
            end
        end
    endtask

    task automatic t_loop();
        wr(`ULMS_OFF_MODEM_CTRL, 32'h19, r);
        repeat (6) @(posedge clk);
        rd(`ULMS_OFF_MODEM_STATUS, v, r);
        chk("looped cd dsr", 32'hAA, v);
        chk("control pins", 32'hF, {28'h0, dtr_n, rts_n, user_output_one_n, user_output_two_n});
        wr(`ULMS_OFF_MODEM_CTRL, 32'h16, r);
        repeat (6) @(posedge clk);
        rd(`ULMS_OFF_MODEM_STATUS, v, r);
        chk("looped ri cts", 32'h5B, v);
        wr(`ULMS_OFF_MODEM_CTRL, 32'h0, r);
        repeat (6) @(posedge clk);
        rd(`ULMS_OFF_MODEM_STATUS, v, r);
        chk("loop exit deltas", 32'h05, v);
    endtask

    task automatic t_irq();
        wr(`ULMS_OFF_IRQ_MASK, 32'h0, r);
        wr(`ULMS_OFF_IRQ_STATUS, 32'hF, r);
        rd(`ULMS_OFF_IRQ_STATUS, v, r);
        chk("irq_status cleared", 32'h0, v);
        @(posedge clk);
        want_n.cts <= 1'h0;
        repeat (6) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(`ULMS_OFF_IRQ_STATUS, v, r);
        chk("irq_status", 32'h1, v);
        wr(`ULMS_OFF_IRQ_MASK, 32'h1, r);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        rd(`ULMS_OFF_MODEM_STATUS, v, r);
        chk("modem_status cts", 32'h11, v);
        wr(`ULMS_OFF_IRQ_STATUS, 32'h1, r);
        repeat (2) @(posedge clk);
        chk("irq after clear", 32'h0, {31'h0, irq});
        rd(8'h40, v, r);
        chk("unmapped read", 32'h2, {30'h0, r});
        chk("unmapped data", 32'h0, v);
        wr(8'h40, 32'h1, r);
        chk("unmapped write", 32'h2, {30'h0, r});
    endtask

    task automatic t_rx();
        wr(`ULMS_OFF_FIFO_CTRL, 32'h1, r);
        push(1, {3'b001, 8'hA5});
        repeat (2) @(posedge clk);
        rd(`ULMS_OFF_LINE_STATUS, v, r);
        chk("line_status parity", 32'h85, v);
        rd(`ULMS_OFF_RX_HOLD, v, r);
        chk("receive_holding", 32'hA5, v);
        rd(`ULMS_OFF_LINE_STATUS, v, r);
        chk("line_status empty", 32'h0, v);
        push(17, {3'b000, 8'h10});
        repeat (2) @(posedge clk);
        rd(`ULMS_OFF_LINE_STATUS, v, r);
        chk("line_status overrun", 32'h3, v);
        rd(`ULMS_OFF_LINE_STATUS, v, r);
        chk("line_status after read", 32'h1, v);
        for (int i = 0; i < 16; i++) begin
            rd(`ULMS_OFF_RX_HOLD, v, r);
            chk("fifo data", 32'h10 + i, v);
        end
        rd(`ULMS_OFF_LINE_STATUS, v, r);
        chk("line_status drained", 32'h0, v);
        // holding mode: depth one, second character overruns
        wr(`ULMS_OFF_FIFO_CTRL, 32'h0, r);
        push(2, {3'b100, 8'h30});
        repeat (2) @(posedge clk);
        rd(`ULMS_OFF_LINE_STATUS, v, r);
        chk("holding overrun", 32'h93, v);
        rd(`ULMS_OFF_RX_HOLD, v, r);
        chk("holding data", 32'h30, v);
    endtask

    // reset with pins active: upper status bits live, deltas clear
    task automatic t_rst_live();
        @(posedge clk);
        want_n <= 4'h5;
        resetn <= 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        repeat (4) @(posedge clk);
        rd(`ULMS_OFF_MODEM_STATUS, v, r);
        chk("modem_status live", 32'hA0, v);
        chk("modem_irq", 32'h0, {31'h0, modem_irq});
    endtask

    initial begin
        clk = 1'h0;
        resetn = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready, rx_valid} = 6'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        rx_char = 11'h000;
        want_n = 4'hF;
        fail_count = 0;
        checks_done = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'h1;
        repeat (4) @(posedge clk);
        t_reset();
        t_modem();
        t_loop();
        t_irq();
        t_rx();
        t_rst_live();
        stop_test();
    end
endmodule
